// ---- inc/irq_ctrl_defines.vh ----
/*
 * Constants of the vectored interrupt controller: register address, bit
 * positions, reset value, vectors and stack depth.
 * Assumes it is included by bare name from the logic files.
 */
`ifndef IRQ_CTRL_DEFINES_VH
`define IRQ_CTRL_DEFINES_VH

`define IRQ_CTRL_ADDR      8'h0B
`define IRQ_BIT_MASTER     0
`define IRQ_BIT_EXT_EN     1
`define IRQ_BIT_TMR0_EN    2
`define IRQ_BIT_TMR1_EN    3
`define IRQ_BIT_EXT_FLAG   4
`define IRQ_BIT_TMR0_FLAG  5
`define IRQ_BIT_TMR1_FLAG  6
`define IRQ_CTRL_RESET     8'h00
`define IRQ_CTRL_RD_MASK   8'h7F
`define IRQ_VEC_EXT        12'h004
`define IRQ_VEC_TMR0       12'h008
`define IRQ_VEC_TMR1       12'h00C
`define IRQ_STACK_DEPTH    4'h8
`define IRQ_NUM_SRC        3

`endif

// ---- logic/irq_sync_edge.v ----
/*
 * Two-flop synchroniser for the active-low external interrupt pin with a
 * falling-edge detector behind it.
 * Assumes the pin is asynchronous to clk_sys; idle level is high.
 */
`timescale 1ns/1ns
`default_nettype none

module irq_sync_edge (
    input wire clk_sys,
    input wire rstn,
    input wire pin_n,
    output reg fall_pulse
);

reg meta_reg;
reg sync_reg;
reg last_reg;

////////////////////////////////////////////////////////////////////////////
// reset to idle-high so release does not fake an edge
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        meta_reg <= 1'b1;
        sync_reg <= 1'b1;
        last_reg <= 1'b1;
        fall_pulse <= 1'b0;
    end else begin
        meta_reg <= pin_n;
        sync_reg <= meta_reg;
        last_reg <= sync_reg;
        fall_pulse <= last_reg & ~sync_reg;
    end
end

endmodule

`default_nettype wire

// ---- logic/irq_priority_pick.v ----
/*
 * Fixed-priority picker: external first, timer 0 second, timer 1 third.
 * Assumes ready bits are already gated by enables and stack room.
 */
`timescale 1ns/1ns
`default_nettype none

`include "irq_ctrl_defines.vh"

module irq_priority_pick (
    input wire [2:0] ready,
    output reg [2:0] grant,
    output reg [11:0] vector
);

always @* begin
    grant = 3'h0;
    vector = 12'h000;
    if (ready[0]) begin
        grant = 3'h1;
        vector = `IRQ_VEC_EXT;
    end else if (ready[1]) begin
        grant = 3'h2;
        vector = `IRQ_VEC_TMR0;
    end else if (ready[2]) begin
        grant = 3'h4;
        vector = `IRQ_VEC_TMR1;
    end
end

endmodule

`default_nettype wire

// ---- logic/vectored_irq_controller.v ----
/*
 * Vectored interrupt controller of a small 8-bit core: control register,
 * request latching, enables, stack-full check, priority and call vector.
 * Assumes the sequencer reports call/return and takes the vector on
 * irq_ack; the control register sits on the core's data-memory port.
 */
// Summary of operation
// - falling external pin sets flag bit 4
// - external serviced: call 04H, clear flag, master
// - timer 0 overflow sets flag bit 5
// - timer 0 serviced: call 08H, clear flag, master
// - timer 1 overflow sets flag bit 6
// - timer 1 serviced: call 0CH, clear flag, master
// - with master off, flags latch, no acknowledge
// - ack held until return or re-enable
// - stack full withholds ack until pop
// - only program counter pushed on acknowledge
// - interrupt return sets master; plain return not
// - requests latched every clock, serviced on phase pulses
// - priority: external, timer 0, timer 1
// - control register at 0BH holds all enables
// - flags stay set until serviced or cleared
// - any source wakes the halted core
// - bit 0 master, bit 1 external enable
// - bits 2,3 timer enables; bit 7 zero
`timescale 1ns/1ns
`default_nettype none

`include "irq_ctrl_defines.vh"

module vectored_irq_controller (
    input wire clk_sys,
    input wire rstn,
    input wire phase_two_pulse,
    input wire ext_irq_n,
    input wire tmr0_overflow,
    input wire tmr1_overflow,
    input wire [7:0] mem_addr,
    input wire mem_wr,
    input wire [7:0] mem_wdata,
    output reg [7:0] mem_rdata,
    input wire call_exec,
    input wire ret_exec,
    input wire return_from_irq,
    input wire halted,
    output reg irq_ack,
    output reg [11:0] irq_vector,
    output reg push_pc,
    output reg wake_up,
    output reg [3:0] stack_index,
    output reg stack_full
);

////////////////////////////////////////////////////////////////////////////
// register fields
reg master_irq_enable;
reg ext_irq_enable;
reg tmr0_irq_enable;
reg tmr1_irq_enable;
reg [2:0] flag_reg;
reg [2:0] flag_next;
reg master_next;
reg [3:0] stack_next;

wire ext_fall;
wire [2:0] hw_set;
wire [2:0] src_enable;
wire [2:0] ready;
wire [2:0] grant;
wire [11:0] vector_pick;
wire ctrl_sel;
wire ctrl_wr;
wire room;
wire take;
wire [7:0] ctrl_view;

wire ext_irq_flag;
wire tmr0_irq_flag;
wire tmr1_irq_flag;

assign ext_irq_flag = flag_reg[0];
assign tmr0_irq_flag = flag_reg[1];
assign tmr1_irq_flag = flag_reg[2];

////////////////////////////////////////////////////////////////////////////
// external pin: synchronised then edge detected
irq_sync_edge u_ext_edge (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pin_n(ext_irq_n),
    .fall_pulse(ext_fall)
);

assign hw_set = {tmr1_overflow, tmr0_overflow, ext_fall};
assign src_enable = {tmr1_irq_enable, tmr0_irq_enable, ext_irq_enable};

assign ctrl_sel = (mem_addr == `IRQ_CTRL_ADDR);
assign ctrl_wr = ctrl_sel & mem_wr;
assign room = (stack_index != `IRQ_STACK_DEPTH);

// flags are only acted on at a phase pulse, so a request between two pulses
// is serviced at the later one
assign ready = flag_reg & src_enable & {3{master_irq_enable & room}};

irq_priority_pick u_pick (
    .ready(ready),
    .grant(grant),
    .vector(vector_pick)
);

// no acknowledge while the sequencer itself pushes or pops this cycle;
// an interrupt return pops too, so a push then would lose that pop
assign take = phase_two_pulse & (|ready) & ~call_exec & ~ret_exec
    & ~return_from_irq;

assign ctrl_view = {1'b0, flag_reg, tmr1_irq_enable, tmr0_irq_enable,
    ext_irq_enable, master_irq_enable} & `IRQ_CTRL_RD_MASK;

////////////////////////////////////////////////////////////////////////////
// flag next state: hardware set wins over software or service clear
genvar gi;
generate
    for (gi = 0; gi < `IRQ_NUM_SRC; gi = gi + 1) begin : g_flag
        always @* begin
            flag_next[gi] = flag_reg[gi];
            if (ctrl_wr) begin
                flag_next[gi] = mem_wdata[`IRQ_BIT_EXT_FLAG + gi];
            end
            if (take & grant[gi]) begin
                flag_next[gi] = 1'b0;
            end
            if (hw_set[gi]) begin
                flag_next[gi] = 1'b1;
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////
// master enable and stack depth
always @* begin
    master_next = master_irq_enable;
    if (ctrl_wr) begin
        master_next = mem_wdata[`IRQ_BIT_MASTER];
    end
    if (return_from_irq) begin
        master_next = 1'b1;
    end
    if (take) begin
        master_next = 1'b0;
    end
end

// a call on a full stack wraps in the core; the depth count saturates
always @* begin
    stack_next = stack_index;
    if (take | call_exec) begin
        if (room) begin
            stack_next = stack_index + 4'h1;
        end
    end else if (ret_exec | return_from_irq) begin
        if (stack_index != 4'h0) begin
            stack_next = stack_index - 4'h1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// state registers
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        master_irq_enable <= 1'b0;
        ext_irq_enable <= 1'b0;
        tmr0_irq_enable <= 1'b0;
        tmr1_irq_enable <= 1'b0;
        flag_reg <= 3'h0;
        stack_index <= 4'h0;
    end else begin
        master_irq_enable <= master_next;
        flag_reg <= flag_next;
        stack_index <= stack_next;
        if (ctrl_wr) begin
            ext_irq_enable <= mem_wdata[`IRQ_BIT_EXT_EN];
            tmr0_irq_enable <= mem_wdata[`IRQ_BIT_TMR0_EN];
            tmr1_irq_enable <= mem_wdata[`IRQ_BIT_TMR1_EN];
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// registered outputs
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        irq_ack <= 1'b0;
        irq_vector <= 12'h000;
        push_pc <= 1'b0;
        wake_up <= 1'b0;
        stack_full <= 1'b0;
        mem_rdata <= 8'h00;
    end else begin
        irq_ack <= take;
        push_pc <= take;
        if (take) begin
            irq_vector <= vector_pick;
        end
        // any set flag wakes the core, whatever the enables
        wake_up <= halted & ((|flag_reg) | (|hw_set));
        stack_full <= (stack_next == `IRQ_STACK_DEPTH);
        mem_rdata <= ctrl_sel ? ctrl_view : 8'h00;
    end
end

endmodule

`default_nettype wire

// ---- tb/irq_seq_model.sv ----
/* Sequencer phase model: one phase_two_pulse every four clocks.
   Assumes one clock and an active-low reset shared with the block. */
`timescale 1ns/1ns
`default_nettype none
module irq_seq_model (
    input wire logic clk_sys,
    input wire logic rstn,
    output logic phase_two_pulse
);
    logic [1:0] cnt_reg;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= 2'h0;
        end else begin
            cnt_reg <= cnt_reg + 2'h1;
        end
    end
    assign phase_two_pulse = (cnt_reg == 2'h3);
endmodule
`default_nettype wire

// ---- tb/irq_ctrl_properties.sv ----
/* Port checker of the interrupt controller.
   Assumes one clock domain; bound to every controller instance. */
`timescale 1ns/1ns
`default_nettype none
module irq_ctrl_properties (
    input wire clk_sys,
    input wire rstn,
    input wire phase_two_pulse,
    input wire tmr0_overflow,
    input wire return_from_irq,
    input wire halted,
    input wire irq_ack,
    input wire push_pc,
    input wire wake_up,
    input wire [3:0] stack_index,
    input wire stack_full
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_ack_on_phase: assert property (irq_ack |-> $past(phase_two_pulse))
        else $error("ack without phase pulse");
    a_push_with_ack: assert property (push_pc == irq_ack)
        else $error("push differs from ack");
    a_no_ack_full: assert property (irq_ack |-> !$past(stack_full))
        else $error("ack while stack full");
    a_ack_pushes: assert property (irq_ack |-> stack_index == $past(stack_index) + 4'h1)
        else $error("ack did not push");
    a_full_depth: assert property (stack_full == (stack_index == 4'h8))
        else $error("full flag wrong");
    a_rti_pops: assert property (return_from_irq && stack_index != 4'h0
        |=> stack_index == $past(stack_index) - 4'h1) else $error("return did not pop");
    a_ack_single: assert property (irq_ack |=> !irq_ack)
        else $error("second ack without re-enable");
    a_wake_timer: assert property (halted && tmr0_overflow |=> wake_up)
        else $error("no wake on timer");
endmodule
bind vectored_irq_controller irq_ctrl_properties i_irq_ctrl_properties (
    .clk_sys(clk_sys), .rstn(rstn), .phase_two_pulse(phase_two_pulse),
    .tmr0_overflow(tmr0_overflow), .return_from_irq(return_from_irq), .halted(halted),
    .irq_ack(irq_ack), .push_pc(push_pc), .wake_up(wake_up),
    .stack_index(stack_index), .stack_full(stack_full));
`default_nettype wire

// ---- tb/tb_top.sv ----
/* Register-level bench of the interrupt controller.
   Assumes the sequencer model supplies the phase pulses. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clk_sys = 0, rstn = 0, ext_irq_n = 1, tmr0_overflow = 0, tmr1_overflow = 0;
    logic mem_wr = 0, call_exec = 0, ret_exec = 0, return_from_irq = 0, halted = 0;
    logic phase_two_pulse, irq_ack, push_pc, wake_up, stack_full;
    logic [7:0] mem_addr = 8'h00, mem_wdata = 8'h00, mem_rdata;
    logic [11:0] irq_vector;
    logic [3:0] stack_index;
    int n_errors = 0, checks = 0;
    always #20 clk_sys = ~clk_sys;
    irq_seq_model i_irq_seq_model (.clk_sys(clk_sys), .rstn(rstn),
        .phase_two_pulse(phase_two_pulse));
    vectored_irq_controller i_vectored_irq_controller (.clk_sys(clk_sys), .rstn(rstn),
        .phase_two_pulse(phase_two_pulse), .ext_irq_n(ext_irq_n),
        .tmr0_overflow(tmr0_overflow), .tmr1_overflow(tmr1_overflow),
        .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .call_exec(call_exec), .ret_exec(ret_exec), .return_from_irq(return_from_irq),
        .halted(halted), .irq_ack(irq_ack), .irq_vector(irq_vector), .push_pc(push_pc),
        .wake_up(wake_up), .stack_index(stack_index), .stack_full(stack_full));
    ////////////////////////////////////////////////////////////////////////////
    task chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input logic [7:0] d);
        @(posedge clk_sys);
        mem_addr <= 8'h0B;
        mem_wdata <= d;
        mem_wr <= 1'b1;
        @(posedge clk_sys);
        mem_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        mem_addr <= a;
        @(posedge clk_sys);
        #1 chk("control", {4'h0, mem_rdata}, {4'h0, e});
    endtask
    // bits: timer 0, timer 1, call, plain return, interrupt return
    task pulse(input logic [4:0] p);
        @(posedge clk_sys);
        {tmr0_overflow, tmr1_overflow, call_exec, ret_exec, return_from_irq} <= p;
        @(posedge clk_sys);
        {tmr0_overflow, tmr1_overflow, call_exec, ret_exec, return_from_irq} <= 5'h00;
    endtask
    // zero means no acknowledge may come; a missing one counts as a mismatch
    task ack(input logic [11:0] e);
        logic [11:0] v;
        v = 12'h000;
        for (int i = 0; i < 24 && v == 12'h000; i++) begin
            @(posedge clk_sys);
            #1 if (irq_ack === 1'b1) v = irq_vector;
        end
        chk("vector", v, e);
    endtask
    task test_done;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(8'h0B, 8'h00);
        rd(8'h0C, 8'h00);
        wr(8'h8E);
        rd(8'h0B, 8'h0E);
        @(posedge clk_sys) ext_irq_n <= 1'b0;
        pulse(5'h18);
        @(posedge clk_sys) ext_irq_n <= 1'b1;
        ack(12'h000);
        rd(8'h0B, 8'h7E);
        $display("test latch done");
        wr(8'h7F);
        ack(12'h004);
        rd(8'h0B, 8'h6E);
        pulse(5'h01);
        ack(12'h008);
        pulse(5'h01);
        ack(12'h00C);
        pulse(5'h01);
        rd(8'h0B, 8'h0F);
        chk("depth", {8'h00, stack_index}, 12'h000);
        $display("test priority done");
        repeat (8) pulse(5'h04);
        #1 chk("full", {11'h000, stack_full}, 12'h001);
        pulse(5'h10);
        ack(12'h000);
        pulse(5'h02);
        ack(12'h008);
        pulse(5'h02);
        rd(8'h0B, 8'h0E);
        $display("test stack done");
        @(posedge clk_sys) halted <= 1'b1;
        pulse(5'h08);
        @(posedge clk_sys);
        #1 chk("wake", {11'h000, wake_up}, 12'h001);
        // write clearing the flags lands with a new timer request; the request must survive
        @(posedge clk_sys);
        {mem_wr, tmr0_overflow} <= 2'b11;
        mem_wdata <= 8'h0E;
        @(posedge clk_sys);
        {mem_wr, tmr0_overflow, halted} <= 3'b000;
        rd(8'h0B, 8'h2E);
        $display("test wake done");
        test_done;
    end
endmodule
`default_nettype wire
